// File: jifr_pkg.sv
// shared constants and types for the ifr control and rx noise filter
package jifr_pkg;
  // noise filter counter
  localparam int FILT_CNT_W = 3;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_MAX = 3'h7;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_MIN = 3'h0;
  localparam logic [FILT_CNT_W-1:0] FILT_CNT_RST = 3'h0;
  localparam logic FILT_OUT_RST = 1'h0;
  localparam logic FILT_SAMP_RST = 1'h0;
  // response-type control field
  localparam int RESP_W = 3;
  localparam int RESP_SINGLE_POS = 2;
  localparam int RESP_MBYTE_POS = 1;
  localparam int RESP_MNODE_POS = 0;
  localparam logic [RESP_W-1:0] RESP_RST = 3'h0;
  localparam logic [RESP_W-1:0] RESP_EFF_NONE = 3'h0;
  localparam logic [RESP_W-1:0] RESP_EFF_SINGLE = 3'h4;
  localparam logic [RESP_W-1:0] RESP_EFF_MBYTE = 3'h2;
  localparam logic [RESP_W-1:0] RESP_EFF_MNODE = 3'h1;
  localparam int BYTE_W = 8;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // response sequencer states
  typedef enum logic [2:0] {
    JIFR_IDLE,
    JIFR_NORM,
    JIFR_BYTE,
    JIFR_CRC,
    JIFR_DONE
  } jifr_state_e;
endpackage : jifr_pkg

// File: jifr_core.sv
// ifr control and rx digital noise filter of the byte link controller
// How it works
// R1 - low-pass filter strips narrow rx noise pulses
// R2 - filter runs on the interface clock
// R3 - rx line sampled on each rising edge
// R4 - sample steers count on next falling edge
// R5 - counter saturates; output flips at limits
// R6 - several type bits: priority single, multi-byte, multi-node
// R7 - readback returns raw written pattern
// R8 - software should set one type bit only
// R9 - forms: none, single, multi-node, multi-byte
// R10 - response starts only after end-of-data
// R11 - lost arbitration: resend id until seen
// R12 - active normalization bit precedes response byte
// R13 - one normalization bit; others sync to it
`timescale 1ns/100ps
`default_nettype none
module jifr_core (
  input wire logic i_sys_clk, // interface clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_clk_en, // freezes all state when low
  input wire logic i_rx_phys_line, // raw receive line
  output logic o_rx_filtered, // filtered receive level
  input wire logic i_resp_wr, // write strobe for type bits
  input wire logic [jifr_pkg::RESP_W-1:0] i_resp_wdata, // type bits written
  output logic [jifr_pkg::RESP_W-1:0] o_resp_rdata, // type bits as written
  output logic [jifr_pkg::RESP_W-1:0] o_resp_eff, // type bits as acted on
  input wire logic i_eod_seen, // end-of-data symbol detected
  input wire logic i_eof_seen, // end-of-frame, aborts response
  input wire logic i_nb_on_bus, // a normalization bit already on bus
  input wire logic i_tx_done, // encoder finished current symbol
  input wire logic i_arb_lost, // arbitration lost this byte
  input wire logic i_rx_byte_valid, // byte received from bus
  input wire logic [jifr_pkg::BYTE_W-1:0] i_rx_byte, // received byte
  input wire logic [jifr_pkg::BYTE_W-1:0] i_own_id, // own id or address
  input wire logic [jifr_pkg::BYTE_W-1:0] i_tx_data, // next multi-byte data
  input wire logic i_last_byte, // current data byte is the last
  input wire logic i_crc_append, // append crc to multi-byte response
  output logic o_tx_nb, // request active normalization bit
  output logic o_tx_byte_req, // request byte transmission
  output logic [jifr_pkg::BYTE_W-1:0] o_tx_byte, // byte to transmit
  output logic o_tx_crc_req, // request crc transmission
  output logic o_ifr_busy, // response in progress
  output logic o_ifr_done // response finished, one pulse
);
  import jifr_pkg::*;

  // priority encoder, used only on write to form the acted-on type bits
  function automatic logic [RESP_W-1:0] resp_prio(input logic [RESP_W-1:0] raw);
    if (raw[RESP_SINGLE_POS]) begin
      resp_prio = RESP_EFF_SINGLE;
    end else if (raw[RESP_MBYTE_POS]) begin
      resp_prio = RESP_EFF_MBYTE;
    end else if (raw[RESP_MNODE_POS]) begin
      resp_prio = RESP_EFF_MNODE;
    end else begin
      resp_prio = RESP_EFF_NONE;
    end
  endfunction : resp_prio

  logic samp;
  logic [FILT_CNT_W-1:0] cnt;
  logic [FILT_CNT_W-1:0] next_cnt;
  logic cnt_at_max;
  logic cnt_at_min;

  // rising edge: sample the raw line
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      samp <= FILT_SAMP_RST;
    end else if (i_clk_en) begin
      samp <= i_rx_phys_line; // R3 R2
    end
  end

  // saturating up/down count; a pulse shorter than the span never reaches a limit
  assign cnt_at_max = (cnt == FILT_CNT_MAX);
  assign cnt_at_min = (cnt == FILT_CNT_MIN);
  assign next_cnt = samp ? (cnt_at_max ? cnt : cnt + 3'h1)
                         : (cnt_at_min ? cnt : cnt - 3'h1); // R4 R5

  // falling edge: step the counter with the last sample
  always_ff @(negedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt <= FILT_CNT_RST;
    end else if (i_clk_en) begin
      cnt <= next_cnt; // R4 R1
    end
  end

  // output flips only at a limit, giving hysteresis against noise
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rx_filtered <= FILT_OUT_RST;
    end else if (i_clk_en) begin
      if (cnt_at_max) begin
        o_rx_filtered <= 1'b1; // R5
      end else if (cnt_at_min) begin
        o_rx_filtered <= 1'b0; // R5
      end
    end
  end

  // type bits: raw copy for readback, encoded copy for the sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_resp_rdata <= RESP_RST;
      o_resp_eff <= RESP_RST;
    end else if (i_clk_en && i_resp_wr) begin
      o_resp_rdata <= i_resp_wdata; // R7
      o_resp_eff <= resp_prio(i_resp_wdata); // R6 R8
    end
  end

  jifr_state_e state;
  jifr_state_e next_state;
  logic lost;
  logic next_lost;
  logic [BYTE_W-1:0] next_tx_byte;
  wire logic is_mbyte = o_resp_eff[RESP_MBYTE_POS];
  wire logic has_ifr = (o_resp_eff != RESP_EFF_NONE); // R9
  wire logic own_seen = i_rx_byte_valid && (i_rx_byte == i_own_id);
  wire logic [BYTE_W-1:0] first_byte = is_mbyte ? i_tx_data : i_own_id;

  // response sequencer
  always_comb begin
    next_state = state;
    next_lost = lost;
    next_tx_byte = o_tx_byte;
    case (state)
      JIFR_IDLE: begin
        if (i_eod_seen && has_ifr) begin
          next_state = JIFR_NORM; // R10
        end
      end
      JIFR_NORM: begin
        // another node's bit is enough; ours would be a second one
        if (i_nb_on_bus || i_tx_done) begin
          next_state = JIFR_BYTE; // R12 R13
          next_lost = 1'b0;
          next_tx_byte = first_byte;
        end
      end
      JIFR_BYTE: begin
        if (i_arb_lost) begin
          next_lost = 1'b1; // R11
        end
        if (!is_mbyte && own_seen) begin
          next_state = JIFR_DONE; // R11
        end else if (i_tx_done && !(lost || i_arb_lost)) begin
          if (!is_mbyte) begin
            next_state = JIFR_DONE;
          end else if (!i_last_byte) begin
            next_tx_byte = i_tx_data;
          end else if (i_crc_append) begin
            next_state = JIFR_CRC; // R9
          end else begin
            next_state = JIFR_DONE;
          end
        end else if (i_tx_done) begin
          next_lost = 1'b0; // resend same byte
        end
      end
      JIFR_CRC: begin
        if (i_tx_done) begin
          next_state = JIFR_DONE;
        end
      end
      default: begin
        next_state = JIFR_IDLE;
      end
    endcase
    if (i_eof_seen && state != JIFR_IDLE) begin
      next_state = JIFR_IDLE; // frame over, give up
    end
  end

  // sequencer registers and request outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= JIFR_IDLE;
      lost <= 1'b0;
      o_tx_byte <= BYTE_RST;
      o_tx_nb <= 1'b0;
      o_tx_byte_req <= 1'b0;
      o_tx_crc_req <= 1'b0;
      o_ifr_busy <= 1'b0;
      o_ifr_done <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      lost <= next_lost;
      o_tx_byte <= next_tx_byte;
      o_tx_nb <= (next_state == JIFR_NORM) && !i_nb_on_bus; // R12 R13
      o_tx_byte_req <= (next_state == JIFR_BYTE); // R11
      o_tx_crc_req <= (next_state == JIFR_CRC);
      o_ifr_busy <= (next_state != JIFR_IDLE); // R10
      o_ifr_done <= (next_state == JIFR_DONE);
    end
  end

  // checks
  sequence s_step_ok;
    i_rst_n && i_clk_en && $past(i_rst_n) && $past(i_clk_en);
  endsequence

  sequence s_nb_taken;
    state == JIFR_NORM && i_nb_on_bus && i_clk_en && !i_eof_seen;
  endsequence

  // normalization phase ends by our own bit or by a rival's
  sequence s_nb_over;
    state == JIFR_NORM && i_clk_en && !i_eof_seen && (i_nb_on_bus || i_tx_done);
  endsequence

  a_filt_count_up: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R4
    s_step_ok and (samp && $past(cnt) != FILT_CNT_MAX) |-> cnt == $past(cnt) + 3'h1)
    else $error("filter counter failed to count up");

  a_filt_count_dn: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
    s_step_ok and (!samp && $past(cnt) == FILT_CNT_MIN) |-> cnt == FILT_CNT_MIN)
    else $error("filter counter did not saturate low");

  a_filt_out_hi: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
    i_clk_en && cnt_at_max |=> o_rx_filtered)
    else $error("filtered output not high at upper limit");

  // filter checks: the low side mirrors the high side
  a_filt_out_lo: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
    i_clk_en && cnt_at_min
      |=> !o_rx_filtered)
    else $error("filtered output not low at lower limit");

  a_samp_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R3
    i_clk_en
      |=> samp == $past(i_rx_phys_line))
    else $error("rx line not sampled on rising edge");

  a_filt_out_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R1
    $past(i_rst_n) && o_rx_filtered != $past(o_rx_filtered) |->
      $past(cnt) == FILT_CNT_MAX || $past(cnt) == FILT_CNT_MIN)
    else $error("filtered output changed away from a limit");

  a_resp_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R7
    i_clk_en && i_resp_wr |=> o_resp_rdata == $past(i_resp_wdata))
    else $error("type readback differs from written pattern");

  a_resp_prio_enc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R6
    i_clk_en && i_resp_wr && !i_resp_wdata[RESP_SINGLE_POS] && i_resp_wdata[RESP_MBYTE_POS]
      |=> o_resp_eff == RESP_EFF_MBYTE ##1 $onehot0(o_resp_eff))
    else $error("type priority encoding wrong");

  // type-bit checks: readback only moves on a write
  a_type_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R7
    i_clk_en && !i_resp_wr
      |=> $stable(o_resp_rdata))
    else $error("type readback changed without a write");

  a_eff_onehot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R6
    $onehot0(o_resp_eff))
    else $error("more than one effective type bit");

  a_ifr_after_eod: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    $past(i_rst_n) && o_ifr_busy && !$past(o_ifr_busy) |-> $past(i_eod_seen))
    else $error("response started without end-of-data");

  a_nb_only_one: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R13
    s_nb_taken |=> !o_tx_nb && o_tx_byte_req)
    else $error("second normalization bit requested");

  // sequencer checks: requests only in their own phase
  a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    state == JIFR_IDLE
      |-> !o_tx_nb && !o_tx_byte_req && !o_tx_crc_req)
    else $error("transmit request while idle");

  a_nb_in_norm: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R12
    o_tx_nb
      |-> state == JIFR_NORM)
    else $error("normalization bit outside its phase");

  a_byte_after_nb: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R12
    s_nb_over
      |=> o_tx_byte_req && !o_tx_nb && o_tx_byte == $past(first_byte))
    else $error("response byte not loaded after normalization");

  a_crc_after_last: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R9
    state == JIFR_BYTE && i_clk_en && !i_eof_seen && is_mbyte && i_tx_done && !lost
      && !i_arb_lost && i_last_byte && i_crc_append |=> o_tx_crc_req)
    else $error("crc not requested after last byte");

  a_done_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R9
    i_clk_en && o_ifr_done
      |=> !o_ifr_done)
    else $error("done pulse longer than one cycle");

  a_eof_abort: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    i_clk_en && i_eof_seen && !i_eod_seen
      |=> !o_ifr_busy)
    else $error("response not dropped at end of frame");

  a_arb_retry_id: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R11
    state == JIFR_BYTE && i_clk_en && i_arb_lost && !is_mbyte && !own_seen && !i_eof_seen
      |=> o_tx_byte_req && o_tx_byte == $past(o_tx_byte))
    else $error("id not resent after lost arbitration");
endmodule : jifr_core
`default_nettype wire

// File: jifr_bus_model.sv
// far-side symbol encoder model: acknowledges every transmit request
`timescale 1ns/100ps
`default_nettype none
module jifr_bus_model (
  input wire logic i_sys_clk, // interface clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_req, // any transmit request of the block
  input wire logic [7:0] i_dly, // cycles before a symbol finishes
  output logic o_tx_done // one-cycle symbol finished pulse
);
  logic [7:0] cnt;
  // the pause after each pulse keeps a request that is about to drop from being counted twice
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !i_req || o_tx_done) begin
      cnt <= 8'h00;
      o_tx_done <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      o_tx_done <= (cnt == i_dly);
    end
  end
endmodule : jifr_bus_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the ifr control and rx noise filter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import jifr_pkg::*;
  logic clk, rst_n, line, wr, eod, eof, last, crc_app, tx_done, filt, busy, done;
  logic nb, breq, creq, nb_first, nbon, arbl;
  logic [2:0] wdata, rdata, eff;
  logic [7:0] tx_data, own_id, dlyv, tx_byte, last_b;
  int failures, comparisons, cyc, nb_n, byte_n, crc_n, k;
  logic [2:0] pats [6] = '{3'h4, 3'h1, 3'h3, 3'h2, 3'h6, 3'h0};

  // echo input stays quiet; the rival scenario drives bus and arbitration status
  jifr_core i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_rx_phys_line(line),
    .o_rx_filtered(filt), .i_resp_wr(wr), .i_resp_wdata(wdata), .o_resp_rdata(rdata),
    .o_resp_eff(eff), .i_eod_seen(eod), .i_eof_seen(eof), .i_nb_on_bus(nbon),
    .i_tx_done(tx_done), .i_arb_lost(arbl), .i_rx_byte_valid(1'b0), .i_rx_byte(8'h00),
    .i_own_id(own_id), .i_tx_data(tx_data), .i_last_byte(last), .i_crc_append(crc_app),
    .o_tx_nb(nb), .o_tx_byte_req(breq), .o_tx_byte(tx_byte), .o_tx_crc_req(creq),
    .o_ifr_busy(busy), .o_ifr_done(done));
  jifr_bus_model i_bus (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(nb | breq | creq),
    .i_dly(dlyv), .o_tx_done(tx_done));

  always #10 clk = ~clk;

  // watchdog and tally of finished symbols
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_done && nb) nb_n <= nb_n + 1;
    if (tx_done && breq) begin
      byte_n <= byte_n + 1;
      last_b <= tx_byte;
      nb_first <= (nb_n != 0);
    end
    if (tx_done && creq) crc_n <= crc_n + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk

  function automatic logic [2:0] prio(input logic [2:0] w);
    if (w[2]) return RESP_EFF_SINGLE;
    if (w[1]) return RESP_EFF_MBYTE;
    if (w[0]) return RESP_EFF_MNODE;
    return RESP_EFF_NONE;
  endfunction : prio

  task automatic set_type(input logic [2:0] w);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= w;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
    chk(rdata === w, "readback differs");
    chk(eff === prio(w), "priority wrong");
  endtask : set_type

  // a glitch against the settled level, then a steady change
  task automatic t_filter(input logic lvl);
    int n;
    @(posedge clk);
    line <= lvl;
    repeat (4) @(posedge clk);
    line <= ~lvl;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk(filt === ~lvl, "glitch passed");
    @(posedge clk);
    line <= lvl;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (filt !== lvl && n < 20);
    chk(n >= 8 && n <= 9, "filter delay");
    $display("test filter %0b done", lvl);
  endtask : t_filter

  task automatic t_ifr(input logic [2:0] ty, input logic [7:0] dly);
    int i;
    logic [2:0] e;
    e = prio(ty);
    set_type(ty);
    @(posedge clk);
    dlyv <= dly;
    crc_app <= ty[0];
    nb_n <= 0;
    byte_n <= 0;
    crc_n <= 0;
    @(negedge clk);
    chk(busy === 1'b0, "busy before eod");
    @(posedge clk);
    eod <= 1'b1;
    @(posedge clk);
    eod <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (done !== 1'b1 && i < 300);
    chk((i < 300) == (e != 3'h0), "response end");
    chk(nb_n == (e != 3'h0), "normalization count");
    chk(byte_n == (e != 3'h0), "byte count");
    chk(e == 3'h0 || nb_first === 1'b1, "byte before nb");
    chk(e == 3'h0 || last_b === (e == RESP_EFF_MBYTE ? tx_data : own_id), "byte value");
    chk(crc_n == (e == RESP_EFF_MBYTE && ty[0]), "crc count");
    $display("test ifr %0h done", ty);
  endtask : t_ifr

  // a rival sends the normalization bit, then we lose arbitration once
  task automatic t_rival();
    int i;
    set_type(3'h1);
    @(posedge clk);
    dlyv <= 8'h03;
    nb_n <= 0;
    byte_n <= 0;
    crc_n <= 0;
    @(posedge clk);
    eod <= 1'b1;
    nbon <= 1'b1;
    @(posedge clk);
    eod <= 1'b0;
    @(posedge clk);
    nbon <= 1'b0;
    @(posedge clk);
    arbl <= 1'b1;
    @(posedge clk);
    arbl <= 1'b0;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (done !== 1'b1 && i < 300);
    chk(i < 300, "rival response end");
    chk(nb_n == 0, "own normalization bit sent");
    chk(byte_n == 2, "id not resent");
    chk(last_b === own_id, "resent byte value");
    $display("test rival done");
  endtask : t_rival

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    {clk, rst_n, line, wr, eod, eof, nb_first} = 7'h00;
    {last, crc_app} = 2'h3;
    {nbon, arbl} = 2'h0;
    wdata = 3'h0;
    tx_data = 8'h5a;
    own_id = 8'ha7;
    dlyv = 8'h01;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(busy === 1'b0 && filt === 1'b0 && rdata === RESP_RST, "reset state");
    t_filter(1'b1);
    t_filter(1'b0);
    for (k = 0; k < 8; k++) set_type(k[2:0]);
    for (k = 0; k < 6; k++) t_ifr(pats[k], 8'(2 * k + 1));
    t_rival();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
